/* File: design/epi_pkg.sv */
package epi_pkg;
  // Register offsets in the data space
  localparam logic [7:0] ADDR_PEND_FLAGS   = 8'h3c;
  localparam logic [7:0] ADDR_ENABLE_MASK  = 8'h3d;
  localparam logic [7:0] ADDR_CHG_FLAGS    = 8'h3b;
  localparam logic [7:0] ADDR_CHG_CONTROL  = 8'h68;
  localparam logic [7:0] ADDR_SENSE_CTRL   = 8'h69;
  localparam logic [7:0] ADDR_CHG_SEL0     = 8'h6b;
  localparam logic [7:0] ADDR_CHG_SEL1     = 8'h6c;
  localparam logic [7:0] ADDR_CHG_SEL2     = 8'h6d;
  // Reset values
  localparam logic [7:0] REG_RESET         = 8'h00;
  // Sense field positions
  localparam int         SENSE_A_LSB       = 0;
  localparam int         SENSE_B_LSB       = 2;
  // Sense encodings
  localparam logic [1:0] SENSE_LOW         = 2'h0;
  localparam logic [1:0] SENSE_ANY         = 2'h1;
  localparam logic [1:0] SENSE_FALL        = 2'h2;
  localparam logic [1:0] SENSE_RISE        = 2'h3;
  // Synchroniser depth
  localparam int         SYNC_STAGES       = 2;
endpackage

/* File: design/epi_sync.sv */
`timescale 1ns/1ns
module epi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // First stage read only by the second
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // epi_sync

/* File: design/epi_sense.sv */
`timescale 1ns/1ns
module epi_sense (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Pin and mode
  input  wire logic       pin_s,
  input  wire logic [1:0] sense,
  // Results
  output logic            edge_hit,
  output logic            level_low
);
  logic prev_q;
  logic rise_w;
  logic fall_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Same value as the synchroniser reset, so no false edge
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_s;
    end
  end

  assign rise_w    = pin_s & ~prev_q;
  assign fall_w    = ~pin_s & prev_q;
  assign level_low = (sense == epi_pkg::SENSE_LOW) & ~pin_s;
  assign edge_hit  = (sense == epi_pkg::SENSE_ANY  & (rise_w | fall_w)) |
                     (sense == epi_pkg::SENSE_FALL & fall_w) |
                     (sense == epi_pkg::SENSE_RISE & rise_w);
endmodule // epi_sense

/* File: design/epi_unit.sv */
`timescale 1ns/1ns
// Summary of operation
// - Pin B sense bits 3:2 select mode
// - Pin A sense bits 1:0 same encoding
// - Sample pin before comparing for edges
// - Pulses over one clock always detected
// - Low level requests while pin low
// - Edges need clock; low level wakes (wake_req is a core_clk flop here, so it needs the clock too)
// - Vanished wake level gives no request
// - Pins configured as outputs still trigger
// - Mask bits 1,0 gate with global flag
// - Edge sets pending flag, core vectors
// - Flag clears on entry or write-one
// - Level mode flag reads cleared
// - Three change groups from pin ranges
// - Per-group select masks choose inputs
// - Change detection wakes from sleep
// - Control bits 2..0 enable groups
// - Group flags set, clear on ack/write-one
module epi_unit #(
  parameter int G0_W = 8,
  parameter int G1_W = 7,
  parameter int G2_W = 8
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // Register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  // Core side
  input  wire logic            core_status_word,
  input  wire logic [4:0]      irq_ack,
  output logic                 ext_pin_a_irq,
  output logic                 ext_pin_b_irq,
  output logic                 change_group_zero_request,
  output logic                 change_group_one_request,
  output logic                 change_group_two_request,
  output logic                 wake_req,
  // Pins, sampled whatever their direction
  input  wire logic            pin_a,
  input  wire logic            pin_b,
  input  wire logic [G0_W-1:0] change_watch_input_g0,
  input  wire logic [G1_W-1:0] change_watch_input_g1,
  input  wire logic [G2_W-1:0] change_watch_input_g2
);
  localparam int CW = G0_W + G1_W + G2_W;

  // Level mode decode, shared by flags, flag reads and wake
  function automatic logic level_mode(input logic [1:0] sense_f);
    return sense_f == epi_pkg::SENSE_LOW;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [1:0]    pin_s;
  logic [CW-1:0] chg_s;
  logic [CW-1:0] chg_prev_q;

  epi_sync #(.WIDTH(2)) u_pin_sync (
    .clk      (core_clk),
    .rst_n    (rst_sync_n),
    .async_in ({pin_b, pin_a}),
    .sync_out (pin_s)
  );

  epi_sync #(.WIDTH(CW)) u_chg_sync (
    .clk      (core_clk),
    .rst_n    (rst_sync_n),
    .async_in ({change_watch_input_g2, change_watch_input_g1,
                change_watch_input_g0}),
    .sync_out (chg_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] sense_q;
  logic [1:0] enable_q;
  logic [1:0] pend_q;
  logic [2:0] grp_en_q;
  logic [2:0] grp_flag_q;
  logic [7:0] sel0_q;
  logic [7:0] sel1_q;
  logic [7:0] sel2_q;

  wire wr_sense = reg_wr & (reg_addr == epi_pkg::ADDR_SENSE_CTRL);
  wire wr_en    = reg_wr & (reg_addr == epi_pkg::ADDR_ENABLE_MASK);
  wire wr_pend  = reg_wr & (reg_addr == epi_pkg::ADDR_PEND_FLAGS);
  wire wr_gen   = reg_wr & (reg_addr == epi_pkg::ADDR_CHG_CONTROL);
  wire wr_gflg  = reg_wr & (reg_addr == epi_pkg::ADDR_CHG_FLAGS);
  wire wr_sel0  = reg_wr & (reg_addr == epi_pkg::ADDR_CHG_SEL0);
  wire wr_sel1  = reg_wr & (reg_addr == epi_pkg::ADDR_CHG_SEL1);
  wire wr_sel2  = reg_wr & (reg_addr == epi_pkg::ADDR_CHG_SEL2);

  ////////////////////////////////////////////////////////////////////////////
  // Dedicated pin detection
  wire [1:0] sense_a = sense_q[epi_pkg::SENSE_A_LSB +: 2];
  wire [1:0] sense_b = sense_q[epi_pkg::SENSE_B_LSB +: 2];
  logic [1:0] edge_hit;
  logic [1:0] level_low;

  epi_sense u_sense_a (
    .clk       (core_clk),
    .rst_n     (rst_sync_n),
    .pin_s     (pin_s[0]),
    .sense     (sense_a),
    .edge_hit  (edge_hit[0]),
    .level_low (level_low[0])
  );

  epi_sense u_sense_b (
    .clk       (core_clk),
    .rst_n     (rst_sync_n),
    .pin_s     (pin_s[1]),
    .sense     (sense_b),
    .edge_hit  (edge_hit[1]),
    .level_low (level_low[1])
  );

  wire [1:0] is_level = {level_mode(sense_b), level_mode(sense_a)};

  // Set beats clear; level mode forces the flag off
  wire [1:0] pend_clr = irq_ack[1:0] | ({2{wr_pend}} & reg_wdata[1:0]);
  wire [1:0] pend_d   = ~is_level &
                        (edge_hit | (pend_q & ~pend_clr));

  ////////////////////////////////////////////////////////////////////////////
  // Pin change detection
  wire [CW-1:0] chg_sel = {sel2_q[G2_W-1:0], sel1_q[G1_W-1:0],
                           sel0_q[G0_W-1:0]};
  wire [CW-1:0] toggled = (chg_s ^ chg_prev_q) & chg_sel;
  wire [2:0] grp_hit = {|toggled[CW-1:G0_W+G1_W],
                        |toggled[G0_W+G1_W-1:G0_W],
                        |toggled[G0_W-1:0]};
  wire [2:0] grp_clr = irq_ack[4:2] | ({3{wr_gflg}} & reg_wdata[2:0]);
  wire [2:0] grp_d   = grp_hit | (grp_flag_q & ~grp_clr);

  ////////////////////////////////////////////////////////////////////////////
  // Requests
  wire       gie     = core_status_word;
  // A level that vanished before sync yields no request
  wire [1:0] pin_req = enable_q & (pend_q | level_low);
  wire [1:0] ext_d   = {2{gie}} & pin_req;
  wire [2:0] grp_d_r = {3{gie}} & grp_en_q & grp_flag_q;
  // Wake looks at raw pins, but wake_req is a core_clk flop, so it needs the clock;
  // besides enabled level-mode pins, only selected inputs of enabled groups may wake the part
  wire [CW-1:0] chg_raw   = {change_watch_input_g2, change_watch_input_g1,
                             change_watch_input_g0};
  wire [CW-1:0] chg_armed = chg_sel & {{G2_W{grp_en_q[2]}},
                                       {G1_W{grp_en_q[1]}},
                                       {G0_W{grp_en_q[0]}}};
  wire wake_w = (enable_q[0] & level_mode(sense_a) & ~pin_a) |
                (enable_q[1] & level_mode(sense_b) & ~pin_b) |
                (|((chg_raw ^ chg_prev_q) & chg_armed));

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      epi_pkg::ADDR_SENSE_CTRL:  rdata_d = {4'h0, sense_q[3:0]};
      epi_pkg::ADDR_ENABLE_MASK: rdata_d = {6'h00, enable_q};
      epi_pkg::ADDR_PEND_FLAGS:  rdata_d = {6'h00, pend_q & ~is_level};
      epi_pkg::ADDR_CHG_CONTROL: rdata_d = {5'h00, grp_en_q};
      epi_pkg::ADDR_CHG_FLAGS:   rdata_d = {5'h00, grp_flag_q};
      epi_pkg::ADDR_CHG_SEL0:    rdata_d = sel0_q;
      epi_pkg::ADDR_CHG_SEL1:    rdata_d = sel1_q;
      epi_pkg::ADDR_CHG_SEL2:    rdata_d = sel2_q;
      default:                   rdata_d = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sense_q    <= epi_pkg::REG_RESET;
      enable_q   <= '0;
      pend_q     <= '0;
      grp_en_q   <= '0;
      grp_flag_q <= '0;
      sel0_q     <= epi_pkg::REG_RESET;
      sel1_q     <= epi_pkg::REG_RESET;
      sel2_q     <= epi_pkg::REG_RESET;
      chg_prev_q <= '0;
    end else begin
      if (wr_sense) sense_q  <= {4'h0, reg_wdata[3:0]};
      if (wr_en)    enable_q <= reg_wdata[1:0];
      if (wr_gen)   grp_en_q <= reg_wdata[2:0];
      if (wr_sel0)  sel0_q   <= reg_wdata;
      if (wr_sel1)  sel1_q   <= {1'b0, reg_wdata[6:0]};
      if (wr_sel2)  sel2_q   <= reg_wdata;
      pend_q     <= pend_d;
      grp_flag_q <= grp_d;
      chg_prev_q <= chg_s;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata                 <= 8'h00;
      ext_pin_a_irq             <= 1'b0;
      ext_pin_b_irq             <= 1'b0;
      change_group_zero_request <= 1'b0;
      change_group_one_request  <= 1'b0;
      change_group_two_request  <= 1'b0;
      wake_req                  <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= rdata_d;
      ext_pin_a_irq             <= ext_d[0];
      ext_pin_b_irq             <= ext_d[1];
      change_group_zero_request <= grp_d_r[0];
      change_group_one_request  <= grp_d_r[1];
      change_group_two_request  <= grp_d_r[2];
      wake_req                  <= wake_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_level_flag_off: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    is_level[0] |=> !pend_q[0])
    else $error("pin a flag set in level mode");

  a_level_flag_b: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    is_level[1] |=> !pend_q[1])
    else $error("pin b flag set in level mode");

  a_set_wins_clear: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    edge_hit[1] && !is_level[1] |=> pend_q[1])
    else $error("pin b edge lost");

  a_write_one_clr: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_gflg && reg_wdata[0] && !grp_hit[0] |=> !grp_flag_q[0])
    else $error("group zero flag not cleared");

  a_write_zero_keep: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    grp_flag_q[1] && !irq_ack[3] && !(wr_gflg && reg_wdata[1])
    |=> grp_flag_q[1])
    else $error("group one flag lost");

  a_gie_gate: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !gie |=> !ext_pin_a_irq && !ext_pin_b_irq)
    else $error("request without global flag");

  a_level_hold: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    gie && enable_q[0] && level_low[0] |=> ext_pin_a_irq)
    else $error("level request missing");

  a_toggle_flag: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    $changed(chg_s[1]) && sel0_q[1] |=> grp_flag_q[0])
    else $error("change not flagged");

  a_group_enable: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !grp_en_q[2] |=> !change_group_two_request)
    else $error("group two request while off");

  a_pin_a_w1c: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_pend && reg_wdata[0] && !edge_hit[0] |=> !pend_q[0])
    else $error("pin a flag not cleared by write");

  a_pin_a_ack: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    irq_ack[0] && !edge_hit[0] |=> !pend_q[0])
    else $error("pin a flag not cleared by ack");

  a_pin_a_req: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    gie && enable_q[0] && pend_q[0] |=> ext_pin_a_irq)
    else $error("pin a request missing");

  a_mask_gate: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !enable_q[0] |=> !ext_pin_a_irq)
    else $error("pin a request while masked");

  a_fall_decode: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    $fell(pin_s[0]) && (sense_a == epi_pkg::SENSE_FALL) |=> pend_q[0])
    else $error("pin a falling edge not flagged");

  a_rise_decode: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    $rose(pin_s[1]) && (sense_b == epi_pkg::SENSE_RISE) |=> pend_q[1])
    else $error("pin b rising edge not flagged");

  a_any_decode: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    $changed(pin_s[0]) && (sense_a == epi_pkg::SENSE_ANY) |=> pend_q[0])
    else $error("pin a change not flagged");

  a_no_false_flag: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !grp_flag_q[0] && !grp_hit[0] |=> !grp_flag_q[0])
    else $error("group zero flag set without change");

  a_group_gie: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !gie |=> !change_group_zero_request && !change_group_one_request &&
             !change_group_two_request)
    else $error("group request without global flag");

  a_group_req: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    gie && grp_en_q[0] && grp_flag_q[0] |=> change_group_zero_request)
    else $error("group zero request missing");

  a_group_ack: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    irq_ack[2] && !grp_hit[0] |=> !grp_flag_q[0])
    else $error("group zero flag not cleared by ack");

  a_wake_level: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    enable_q[0] && level_mode(sense_a) && !pin_a |=> wake_req)
    else $error("level wake missing");

  a_level_gone: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !level_low[0] && !pend_q[0] |=> !ext_pin_a_irq)
    else $error("request after level vanished");
endmodule // epi_unit

/* File: verif/epi_pins.sv */
`timescale 1ns/1ns
module epi_pins (
  // Clock
  input  wire logic       core_clk,
  // Pins
  output logic            pin_a,
  output logic            pin_b,
  output logic      [7:0] change_watch_input_g0,
  output logic      [6:0] change_watch_input_g1,
  output logic      [7:0] change_watch_input_g2
);
  // Order: a, b, group 0, group 1, group 2
  logic [24:0] lvl_q;

  // Idle high, as with the pull-up on
  initial lvl_q = 25'h1ff_ffff;

  assign pin_a                 = lvl_q[0];
  assign pin_b                 = lvl_q[1];
  assign change_watch_input_g0 = lvl_q[9:2];
  assign change_watch_input_g1 = lvl_q[16:10];
  assign change_watch_input_g2 = lvl_q[24:17];

  ////////////////////////////////////////////////////////////////////////////
  // Level held until told otherwise, so a low level outlasts any access
  task automatic set(input int i, input logic v);
    lvl_q[i] = v;
  endtask

  // Never shorter than two cycles; one cycle is not promised to be seen
  task automatic pulse(input int i, input int n);
    lvl_q[i] = ~lvl_q[i];
    repeat (n) @(posedge core_clk);
    #1;
    lvl_q[i] = ~lvl_q[i];
  endtask
endmodule // epi_pins

/* File: verif/tb_epi_unit.sv */
`timescale 1ns/1ns
module tb_epi_unit;
  logic       core_clk, rst_n, reg_wr, reg_rd, gie;
  logic [7:0] reg_addr, reg_wdata, rd_v;
  logic [4:0] irq_ack;
  wire  [7:0] reg_rdata;
  wire  [4:0] irqs;
  wire        wake, pin_a, pin_b;
  wire  [7:0] g0, g2;
  wire  [6:0] g1;
  int         mismatches, num_checks, b;
  logic [7:0] ra [9] = '{8'h3b, 8'h3c, 8'h3d, 8'h68, 8'h69, 8'h6b, 8'h6c,
                         8'h6d, 8'h50};
  logic [7:0] wa [5] = '{8'h3d, 8'h68, 8'h69, 8'h6c, 8'h50};
  logic [7:0] we [5] = '{8'h03, 8'h07, 8'h0f, 8'h7f, 8'h00};
  logic [1:0] md [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
  logic [5:0] st     = 6'h19;
  logic [5:0] ex     = 6'h35;

  epi_unit epi_unit_inst (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_status_word(gie),
    .irq_ack(irq_ack), .ext_pin_a_irq(irqs[0]), .ext_pin_b_irq(irqs[1]),
    .change_group_zero_request(irqs[2]), .change_group_one_request(irqs[3]),
    .change_group_two_request(irqs[4]), .wake_req(wake), .pin_a(pin_a),
    .pin_b(pin_b), .change_watch_input_g0(g0), .change_watch_input_g1(g1),
    .change_watch_input_g2(g2));
  epi_pins epi_pins_inst (.core_clk(core_clk), .pin_a(pin_a), .pin_b(pin_b),
    .change_watch_input_g0(g0), .change_watch_input_g1(g1),
    .change_watch_input_g2(g2));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    // Idle edge, so a following write never re-raises the strobe at once
    step(1);
  endtask
  // Waits a spare edge so either reading of the load edge is safe
  task automatic rdchk(input logic [7:0] a, e, input string nm);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    check(nm, reg_rdata, e);
  endtask
  task automatic ack(input logic [4:0] v);
    irq_ack = v;
    step(1);
    irq_ack = 5'h00;
    step(3);
  endtask
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, gie, reg_addr, reg_wdata, irq_ack} = '0;
    step(3);
    rst_n = 1'b1;
    step(3);
    foreach (ra[i]) rdchk(ra[i], 8'h00, "reset value");
    foreach (wa[i]) begin
      wr(wa[i], 8'hff);
      rdchk(wa[i], we[i], "write mask");
      wr(wa[i], 8'h00);
    end
    // Edge table per pin, flag cleared just before the event
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 6; k++) begin
        wr(8'h69, 8'(md[k]) << (2 * p));
        epi_pins_inst.set(p, st[k]);
        step(8);
        wr(8'h3c, 8'h03);
        epi_pins_inst.set(p, ~st[k]);
        step(8);
        rdchk(8'h3c, 8'(ex[k]) << p, "edge flag");
      end
    end
    wr(8'h69, 8'h02);
    wr(8'h3c, 8'h03);
    epi_pins_inst.pulse(0, 2);
    step(8);
    rdchk(8'h3c, 8'h01, "pulse flag");
    check("no enable", {3'h0, irqs}, 8'h00);
    wr(8'h3d, 8'h01);
    step(3);
    check("no global", {3'h0, irqs}, 8'h00);
    gie = 1'b1;
    step(3);
    check("request a", {3'h0, irqs}, 8'h01);
    wr(8'h3c, 8'h00);
    rdchk(8'h3c, 8'h01, "write zero");
    ack(5'h01);
    check("ack drop", {3'h0, irqs}, 8'h00);
    rdchk(8'h3c, 8'h00, "ack flag");
    epi_pins_inst.pulse(0, 2);
    step(8);
    check("request again", {3'h0, irqs}, 8'h01);
    wr(8'h3c, 8'h01);
    step(3);
    rdchk(8'h3c, 8'h00, "write one");
    // Low level: request stands while low, flag stays clear
    wr(8'h69, 8'h00);
    epi_pins_inst.set(0, 1'b0);
    step(8);
    check("level req", {3'h0, irqs}, 8'h01);
    check("level wake", {7'h0, wake}, 8'h01);
    rdchk(8'h3c, 8'h00, "level flag");
    epi_pins_inst.set(0, 1'b1);
    step(8);
    check("level gone", {3'h0, irqs}, 8'h00);
    wr(8'h3d, 8'h00);
    // Change groups: bit 0 unselected, bit 1 selected
    for (int g = 0; g < 3; g++) begin
      b = 2 + 8 * g - g / 2;
      wr(8'h68, 8'h01 << g);
      wr(8'(8'h6b + g), 8'h02);
      epi_pins_inst.set(b, 1'b0);
      step(1);
      check("quiet wake", {7'h0, wake}, 8'h00);
      step(7);
      rdchk(8'h3b, 8'h00, "unselected");
      epi_pins_inst.set(b + 1, 1'b0);
      step(1);
      check("change wake", {7'h0, wake}, 8'h01);
      step(7);
      rdchk(8'h3b, 8'h01 << g, "group flag");
      check("group req", {3'h0, irqs}, 8'h04 << g);
      ack(5'h04 << g);
      rdchk(8'h3b, 8'h00, "group ack");
      epi_pins_inst.set(b, 1'b1);
      epi_pins_inst.set(b + 1, 1'b1);
      step(8);
      rdchk(8'h3b, 8'h01 << g, "group again");
      wr(8'h3b, 8'h07);
      rdchk(8'h3b, 8'h00, "group w1c");
    end
    stop_test;
  end
endmodule // tb_epi_unit
